/* pkg/srst_pkg.sv */
package srst_pkg;

  localparam int          SRST_ADDR_W   = 12;
  localparam int          SRST_NBITS    = 4;
  localparam int          SRST_CNT_W    = 16;

  // register map
  localparam logic [11:0] SRST_CTL_OFS  = 12'h1f8;
  localparam logic [3:0]  SRST_CTL_RST  = 4'h0;
  localparam logic [27:0] SRST_RSVD_VAL = 28'h0;
  localparam logic [31:0] SRST_ZERO_W   = 32'h0;

  // bit positions
  localparam int          SRST_DIG_BIT  = 0;
  localparam int          SRST_P1_BIT   = 1;
  localparam int          SRST_P2_BIT   = 2;
  localparam int          SRST_VPHY_BIT = 3;
  localparam int          SRST_STRB_LO  = 0;

  // timing
  localparam int          SRST_CLK_NS   = 4;
  localparam int          SRST_PHY_NS   = 102000;
  localparam int          SRST_PHY_CYC  = (SRST_PHY_NS + SRST_CLK_NS - 1) / SRST_CLK_NS;
  localparam logic [15:0] SRST_DIG_HOLD = 16'h0008;
  localparam logic [15:0] SRST_VPHY_HLD = 16'h0008;
  localparam logic [15:0] SRST_CNT_ONE  = 16'h0001;
  localparam logic [15:0] SRST_CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    DR_IDLE   = 2'b00,
    DR_HOLD   = 2'b01,
    DR_RELOAD = 2'b10
  } srst_dr_t;

endpackage

/* verilog/srst_hold_tmr.sv */
`timescale 1ns/10ps
module srst_hold_tmr
  import srst_pkg::*;
#(
  parameter logic [15:0] HOLD_CYC = SRST_VPHY_HLD
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic start,
  output      logic done
);

  typedef struct packed {
    logic                  busy;
    logic [SRST_CNT_W-1:0] cnt;
  } srst_tmr_st_t;

  srst_tmr_st_t st_r;
  srst_tmr_st_t st_nxt;

  // done marks the last held cycle
  assign done = st_r.busy && (st_r.cnt == SRST_CNT_ONE);

  always_comb begin
    st_nxt = st_r;
    if (start && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = HOLD_CYC;
    end else if (st_r.busy) begin
      if (st_r.cnt == SRST_CNT_ONE) begin
        st_nxt.busy = 1'b0;
        st_nxt.cnt  = SRST_CNT_ZERO;
      end else begin
        st_nxt.cnt = st_r.cnt - SRST_CNT_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

/* verilog/srst_top.sv */
`timescale 1ns/10ps
module srst_top
  import srst_pkg::*;
#(
  parameter logic [15:0] PHY_HOLD = 16'(SRST_PHY_CYC)
) (
  // apb clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb request
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [SRST_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  // apb answer
  output      logic [31:0]            prdata,
  output      logic                   pready,
  output      logic                   pslverr,
  // chip-wide digital reset and loader control
  output      logic                   chip_soft_reset,
  output      logic                   eep_abort,
  output      logic                   eep_reload,
  // phy resets
  output      logic                   virtual_phy_reset,
  output      logic                   port_one_phy_reset,
  output      logic                   port_two_phy_reset
);

  typedef struct packed {
    logic [SRST_NBITS-1:0] ctl;
    logic                  armed;
    srst_dr_t              dr;
    logic [SRST_CNT_W-1:0] dcnt;
    logic                  chip_rst;
    logic                  abort;
    logic                  reload;
    logic                  rdy;
    logic                  err;
    logic [31:0]           rdata;
  } srst_top_st_t;

  srst_top_st_t          st_r;
  srst_top_st_t          st_nxt;
  logic                  acc;
  logic                  fin;
  logic                  hit;
  logic                  wr_ok;
  logic [SRST_NBITS-1:0] set_req;
  logic [SRST_NBITS-1:0] tmr_done;
  logic [31:0]           rd_word;

  // phy hold timers, one per phy bit
  assign tmr_done[SRST_DIG_BIT] = 1'b0;

  genvar g;
  generate
    for (g = SRST_P1_BIT; g < SRST_NBITS; g++) begin : g_phy
      srst_hold_tmr #(
        .HOLD_CYC ((g == SRST_VPHY_BIT) ? SRST_VPHY_HLD : PHY_HOLD)
      ) srst_hold_tmr_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (set_req[g]),
        .done    (tmr_done[g])
      );
    end
  endgenerate

  // bus decode
  assign acc = psel && penable;
  assign fin = acc && st_r.rdy;
  assign hit = (paddr[SRST_ADDR_W-1:2] == SRST_CTL_OFS[SRST_ADDR_W-1:2]);

  // the register answers from presetn alone, whatever the chip state
  assign rd_word = {SRST_RSVD_VAL, st_r.ctl};

  // only the apb port reaches the bits; the loader has no path here
  assign wr_ok = fin && pwrite && hit && pstrb[SRST_STRB_LO] && st_r.armed;

  always_comb begin
    for (int i = 0; i < SRST_NBITS; i++) begin
      set_req[i] = wr_ok && pwdata[i] && !st_r.ctl[i];
    end
  end

  // next state
  always_comb begin
    st_nxt        = st_r;
    st_nxt.reload = 1'b0;

    // one wait state, then the answer
    st_nxt.rdy = acc && !st_r.rdy;
    if (acc && !st_r.rdy) begin
      st_nxt.err   = !hit;
      st_nxt.rdata = (hit && !pwrite) ? rd_word : SRST_ZERO_W;
    end

    // a completed read arms writes
    if (fin && !pwrite) begin
      st_nxt.armed = 1'b1;
    end

    // phy bits: set by host, cleared when the phy leaves reset
    for (int i = SRST_P1_BIT; i < SRST_NBITS; i++) begin
      if (set_req[i]) begin
        st_nxt.ctl[i] = 1'b1;
      end else if (tmr_done[i]) begin
        st_nxt.ctl[i] = 1'b0;
      end
    end

    // chip digital reset; phy bits above are untouched by it
    case (st_r.dr)
      DR_IDLE: begin
        if (set_req[SRST_DIG_BIT]) begin
          st_nxt.ctl[SRST_DIG_BIT] = 1'b1;
          st_nxt.dr                = DR_HOLD;
          st_nxt.dcnt              = SRST_DIG_HOLD;
          st_nxt.chip_rst          = 1'b1;
          st_nxt.abort             = 1'b1;
        end
      end
      DR_HOLD: begin
        if (st_r.dcnt == SRST_CNT_ONE) begin
          st_nxt.dr       = DR_RELOAD;
          st_nxt.dcnt     = SRST_CNT_ZERO;
          st_nxt.chip_rst = 1'b0;
          st_nxt.abort    = 1'b0;
          st_nxt.armed    = 1'b0;
        end else begin
          st_nxt.dcnt = st_r.dcnt - SRST_CNT_ONE;
        end
      end
      DR_RELOAD: begin
        st_nxt.reload            = 1'b1;
        st_nxt.ctl[SRST_DIG_BIT] = 1'b0;
        st_nxt.dr                = DR_IDLE;
      end
      default: begin
        st_nxt.dr       = DR_IDLE;
        st_nxt.chip_rst = 1'b0;
        st_nxt.abort    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= '0;
      st_r.ctl   <= SRST_CTL_RST;
      st_r.dr    <= DR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign prdata             = st_r.rdata;
  assign pready             = st_r.rdy;
  assign pslverr            = st_r.err;
  assign chip_soft_reset    = st_r.chip_rst;
  assign eep_abort          = st_r.abort;
  assign eep_reload         = st_r.reload;
  assign virtual_phy_reset  = st_r.ctl[SRST_VPHY_BIT];
  assign port_one_phy_reset = st_r.ctl[SRST_P1_BIT];
  assign port_two_phy_reset = st_r.ctl[SRST_P2_BIT];

  // checks
  logic [SRST_CNT_W:0] hold_cnt_r [SRST_P1_BIT:SRST_P2_BIT];

  // counts cycles that each port phy stays in reset
  for (genvar p = SRST_P1_BIT; p <= SRST_P2_BIT; p++) begin : g_hold
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hold_cnt_r[p] <= '0;
      end else if (st_r.ctl[p]) begin
        hold_cnt_r[p] <= hold_cnt_r[p] + (SRST_CNT_W+1)'(1);
      end else begin
        hold_cnt_r[p] <= '0;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rd_req;
    psel && penable && !pready && !pwrite && hit;
  endsequence

  sequence s_rd_ans(logic [3:0] v);
    pready && !pslverr && (prdata == {SRST_RSVD_VAL, v});
  endsequence

  property p_rd_any_state;
    logic [3:0] v;
    (s_rd_req, v = st_r.ctl) |=> s_rd_ans(v);
  endproperty
  a_rd_any_state: assert property (p_rd_any_state)
    else $error("reset control read not answered with its value");

  property p_rsvd_zero;
    pready |-> (prdata[31:SRST_NBITS] == SRST_RSVD_VAL);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits of reset control not zero");

  property p_vphy_pulse;
    $rose(virtual_phy_reset) |-> virtual_phy_reset[*8] ##1 !virtual_phy_reset;
  endproperty
  a_vphy_pulse: assert property (p_vphy_pulse)
    else $error("virtual phy reset length wrong");

  property p_phy_min_hold;
    $fell(port_one_phy_reset) |-> (hold_cnt_r[SRST_P1_BIT] == {1'b0, PHY_HOLD});
  endproperty
  a_phy_min_hold: assert property (p_phy_min_hold)
    else $error("port one phy released before its hold time");

  property p_phy_clr;
    tmr_done[SRST_P2_BIT] |=> !port_two_phy_reset;
  endproperty
  a_phy_clr: assert property (p_phy_clr)
    else $error("port two phy bit did not clear at release");

  property p_write_ignored;
    port_one_phy_reset && !tmr_done[SRST_P1_BIT] |=> port_one_phy_reset;
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("port one phy bit changed while set");

  sequence s_chip_hold;
    chip_soft_reset[*8];
  endsequence

  sequence s_chip_release;
    (!chip_soft_reset && st_r.ctl[SRST_DIG_BIT])
    ##1 (eep_reload && !st_r.ctl[SRST_DIG_BIT]);
  endsequence

  property p_chip_seq;
    $rose(chip_soft_reset) |-> s_chip_hold ##1 s_chip_release;
  endproperty
  a_chip_seq: assert property (p_chip_seq)
    else $error("digital reset sequence wrong");

  property p_abort_with_reset;
    $rose(chip_soft_reset) |-> eep_abort ##1 (eep_abort == chip_soft_reset);
  endproperty
  a_abort_with_reset: assert property (p_abort_with_reset)
    else $error("eeprom abort not tied to digital reset");

  property p_chip_spares_phy;
    $rose(chip_soft_reset) && port_two_phy_reset && !tmr_done[SRST_P2_BIT]
      |=> port_two_phy_reset;
  endproperty
  a_chip_spares_phy: assert property (p_chip_spares_phy)
    else $error("digital reset disturbed a phy reset");

  property p_zero_write;
    !st_r.ctl[SRST_DIG_BIT] && !set_req[SRST_DIG_BIT] |=> !chip_soft_reset || $past(chip_soft_reset);
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("digital reset started without a one written");

  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready held longer than one cycle");

  property p_one_wait;
    acc && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("access phase not answered after one wait state");

  property p_unmapped_err;
    acc && !pready && !hit |=> pready && pslverr && (prdata == SRST_ZERO_W);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not refused");

  property p_host_only_set;
    $rose(port_one_phy_reset) |-> $past(wr_ok && pwdata[SRST_P1_BIT]);
  endproperty
  a_host_only_set: assert property (p_host_only_set)
    else $error("port one phy reset raised without a host write");

  property p_disarmed;
    fin && pwrite && !st_r.armed && !port_one_phy_reset |=> !port_one_phy_reset;
  endproperty
  a_disarmed: assert property (p_disarmed)
    else $error("write took effect before the first read");

  property p_reload_pulse;
    eep_reload |=> !eep_reload;
  endproperty
  a_reload_pulse: assert property (p_reload_pulse)
    else $error("configuration reload pulse too long");

  property p_dig_bit_held;
    chip_soft_reset |-> st_r.ctl[SRST_DIG_BIT];
  endproperty
  a_dig_bit_held: assert property (p_dig_bit_held)
    else $error("digital reset bit cleared while chip held in reset");

  property p_dig_set;
    wr_ok && pwdata[SRST_DIG_BIT] && !st_r.ctl[SRST_DIG_BIT] |=> chip_soft_reset && eep_abort;
  endproperty
  a_dig_set: assert property (p_dig_set)
    else $error("digital reset not started by a one written");

  property p_p1_set;
    wr_ok && pwdata[SRST_P1_BIT] && !port_one_phy_reset |=> port_one_phy_reset;
  endproperty
  a_p1_set: assert property (p_p1_set)
    else $error("port one phy reset not started by a one written");

  property p_p2_set;
    wr_ok && pwdata[SRST_P2_BIT] && !port_two_phy_reset |=> port_two_phy_reset;
  endproperty
  a_p2_set: assert property (p_p2_set)
    else $error("port two phy reset not started by a one written");

  property p_vphy_set;
    wr_ok && pwdata[SRST_VPHY_BIT] && !virtual_phy_reset |=> virtual_phy_reset;
  endproperty
  a_vphy_set: assert property (p_vphy_set)
    else $error("virtual phy reset not started by a one written");

  property p_p1_clr;
    tmr_done[SRST_P1_BIT] |=> !port_one_phy_reset;
  endproperty
  a_p1_clr: assert property (p_p1_clr)
    else $error("port one phy bit did not clear at release");

  property p_p2_min_hold;
    $fell(port_two_phy_reset) |-> (hold_cnt_r[SRST_P2_BIT] == {1'b0, PHY_HOLD});
  endproperty
  a_p2_min_hold: assert property (p_p2_min_hold)
    else $error("port two phy released before its hold time");

endmodule

/* test/srst_top_test.sv */
`timescale 1ns/10ps
module srst_top_test;
  import srst_pkg::*;

  localparam logic [15:0] PH  = 16'h0014;
  localparam logic [11:0] CTL = SRST_CTL_OFS;

  typedef struct {
    logic        chk;
    logic [31:0] d;
    logic        e;
  } srst_exp_t;

  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [SRST_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [3:0]             pstrb;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   chip_soft_reset;
  logic                   eep_abort;
  logic                   eep_reload;
  logic                   virtual_phy_reset;
  logic                   port_one_phy_reset;
  logic                   port_two_phy_reset;
  logic [5:0]             outs;
  logic [31:0]            rd;
  srst_exp_t              q[$];
  srst_exp_t              cur;
  int                     len_q[6][$];
  int                     run[6];
  int                     n_errors;
  int                     comparisons;
  int                     n;

  // watched output levels: chip, abort, reload, vphy, port one, port two
  assign outs = {port_two_phy_reset, port_one_phy_reset, virtual_phy_reset,
                 eep_reload, eep_abort, chip_soft_reset};

  srst_top #(.PHY_HOLD(PH)) srst_top_inst (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .chip_soft_reset    (chip_soft_reset),
    .eep_abort          (eep_abort),
    .eep_reload         (eep_reload),
    .virtual_phy_reset  (virtual_phy_reset),
    .port_one_phy_reset (port_one_phy_reset),
    .port_two_phy_reset (port_two_phy_reset)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task cmp_len(input string nm, input int e, input int g);
    comparisons++;
    if (g != e) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task report_and_stop();
    for (int i = 0; i < 6; i++) cmp_len("pulses still owed", 0, len_q[i].size());
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer; upper write data bits are random
  task apb(input logic w, input logic [11:0] a, input logic [3:0] d, input logic [3:0] s,
           input logic chk, input logic [31:0] ed, input logic ee);
    int          k;
    logic [31:0] r;
    r = $urandom();
    q.push_back('{chk, ed, ee});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pstrb   <= s;
    pwdata  <= {r[31:4], d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // answer checker and pulse length watcher
  always @(posedge pclk) begin
    if (presetn === 1'b1 && psel && penable && pready === 1'b1) begin
      if (q.size() == 0) cmp_len("unexpected answer", 0, 1);
      else begin
        cur = q.pop_front();
        cmp_word("pslverr", {31'h0, cur.e}, {31'h0, pslverr});
        if (cur.chk) cmp_word("prdata", cur.d, prdata);
      end
    end
    for (int i = 0; i < 6; i++) begin
      if (outs[i] === 1'b1) run[i]++;
      else if (run[i] > 0) begin
        if (len_q[i].size() > 0) cmp_len("pulse length", len_q[i].pop_front(), run[i]);
        else cmp_len("unexpected pulse", 0, run[i]);
        run[i] = 0;
      end
    end
  end

  initial begin
    n_errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    rd = $urandom(21);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, CTL, 4'h2, 4'h1, 1'b0, 32'h0, 1'b0);
    apb(1'b0, CTL, 4'h0, 4'h0, 1'b1, 32'h0, 1'b0);
    apb(1'b0, 12'h1fc, 4'h0, 4'h0, 1'b1, 32'h0, 1'b1);
    apb(1'b1, CTL, 4'h2, 4'h0, 1'b0, 32'h0, 1'b0);
    apb(1'b0, CTL, 4'h0, 4'h0, 1'b1, 32'h0, 1'b0);
    len_q[4].push_back(PH);
    apb(1'b1, CTL, 4'h2, 4'h1, 1'b0, 32'h0, 1'b0);
    apb(1'b0, CTL, 4'h0, 4'h0, 1'b1, 32'h2, 1'b0);
    apb(1'b1, CTL, 4'h0, 4'h1, 1'b0, 32'h0, 1'b0);
    apb(1'b1, CTL, 4'h2, 4'h1, 1'b0, 32'h0, 1'b0);
    apb(1'b0, CTL, 4'h0, 4'h0, 1'b1, 32'h2, 1'b0);
    repeat (PH) @(posedge pclk);
    apb(1'b0, CTL, 4'h0, 4'h0, 1'b1, 32'h0, 1'b0);
    len_q[5].push_back(PH);
    len_q[3].push_back(8);
    apb(1'b1, CTL, 4'h4, 4'h1, 1'b0, 32'h0, 1'b0);
    apb(1'b1, CTL, 4'h8, 4'h1, 1'b0, 32'h0, 1'b0);
    len_q[0].push_back(8);
    len_q[1].push_back(8);
    len_q[2].push_back(1);
    // port two hold must run on untouched through the chip reset
    apb(1'b1, CTL, 4'h1, 4'h1, 1'b0, 32'h0, 1'b0);
    apb(1'b0, CTL, 4'h0, 4'h0, 1'b0, 32'h0, 1'b0);
    cmp_word("bit0 during reset", 32'h1, {31'h0, rd[0]});
    n = 0;
    do begin
      apb(1'b0, CTL, 4'h0, 4'h0, 1'b0, 32'h0, 1'b0);
      n++;
    end while (rd[0] !== 1'b0 && n < 10);
    cmp_word("bit0 after poll", 32'h0, {31'h0, rd[0]});
    repeat (PH + 10) @(posedge pclk);
    len_q[3].push_back(8);
    apb(1'b1, CTL, 4'h8, 4'h1, 1'b0, 32'h0, 1'b0);
    repeat (12) @(posedge pclk);
    apb(1'b0, CTL, 4'h0, 4'h0, 1'b1, 32'h0, 1'b0);
    report_and_stop();
  end
endmodule
